/* hdl/tbfr_regs.v */
// Notes on behaviour
// - bias code is high register plus two bits
// - closed loop step by range code
// - open loop step about 156 uA per code
// - bit 6 selects digital photodiode monitor
// - bit 5 selects digital bias monitor
// - bias threshold sets digital bias fault level
// - power threshold sets photodiode fault level
// - all five registers read, write, reset zero
// - status bit reads one while fault present
`include "tbfr_consts.vh"

module tbfr_regs #(
    parameter [6:0] DEV_ADDR = `TBFR_DEV_ADDR_DEFAULT,
    parameter LEVEL_W = 8
) (
    input wire sys_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire closed_loop_power_control,
    input wire [1:0] monitor_pd_range,
    input wire [LEVEL_W-1:0] bias_monitor_level,
    input wire [LEVEL_W-1:0] pd_monitor_level,
    output reg [9:0] laser_bias_code,
    output reg [17:0] bias_step_na,
    output reg pd_monitor_digital_sel,
    output reg bias_monitor_digital_sel,
    output reg [7:0] bias_fault_threshold,
    output reg [7:0] power_fault_threshold,
    output reg [7:0] freq_detect_divider_ctrl,
    output reg tx_fault_flag
);

// ==========================================
// states
localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_ADDR = 4'h1;
localparam [3:0] ST_ADDR_ACK = 4'h2;
localparam [3:0] ST_REG = 4'h3;
localparam [3:0] ST_REG_ACK = 4'h4;
localparam [3:0] ST_WDATA = 4'h5;
localparam [3:0] ST_WDATA_ACK = 4'h6;
localparam [3:0] ST_RDATA = 4'h7;
localparam [3:0] ST_RDATA_ACK = 4'h8;

// ==========================================
// register storage
reg [7:0] bias_code_high;
reg [7:0] monitor_select_bias_low;
reg [7:0] bias_fault_threshold_reg;
reg [7:0] power_fault_threshold_reg;
reg [7:0] freq_detect_divider_ctrl_reg;
reg [3:0] state;
reg [3:0] bit_cnt;
reg [7:0] shreg;
reg [7:0] reg_ptr;
reg rw;

// ==========================================
// pin synchronisers
reg scl_m;
reg scl_s;
reg scl_d;
reg sda_m;
reg sda_s;
reg sda_d;

always @(posedge sys_clk) begin
    if (!rst_n) begin
        scl_m <= 1'b1;
        scl_s <= 1'b1;
        scl_d <= 1'b1;
        sda_m <= 1'b1;
        sda_s <= 1'b1;
        sda_d <= 1'b1;
    end else begin
        scl_m <= scl_in;
        scl_s <= scl_m;
        scl_d <= scl_s;
        sda_m <= sda_in;
        sda_s <= sda_m;
        sda_d <= sda_s;
    end
end

wire scl_rise = scl_s && !scl_d;
wire scl_fall = !scl_s && scl_d;
wire bus_start = scl_s && scl_d && sda_d && !sda_s;
wire bus_stop = scl_s && scl_d && !sda_d && sda_s;

// ==========================================
// fault detection
wire bias_fault;
wire pd_fault;

tbfr_fault_cmp #(
    .WIDTH(LEVEL_W)
) u_bias_cmp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(monitor_select_bias_low[`TBFR_BIT_BIAS_DIG_SEL]),
    .level(bias_monitor_level),
    .threshold(bias_fault_threshold_reg),
    .fault(bias_fault)
);

tbfr_fault_cmp #(
    .WIDTH(LEVEL_W)
) u_pd_cmp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(monitor_select_bias_low[`TBFR_BIT_PD_DIG_SEL]),
    .level(pd_monitor_level),
    .threshold(power_fault_threshold_reg),
    .fault(pd_fault)
);

// ==========================================
// read data mux
reg [7:0] rd_data;

always @* begin
    rd_data = 8'h00;
    case (reg_ptr)
        `TBFR_REG_BIAS_HIGH: begin
            rd_data = bias_code_high;
        end
        `TBFR_REG_MON_SEL_LOW: begin
            rd_data = monitor_select_bias_low;
        end
        `TBFR_REG_BIAS_FAULT_TH: begin
            rd_data = bias_fault_threshold_reg;
        end
        `TBFR_REG_POWER_FAULT_TH: begin
            rd_data = power_fault_threshold_reg;
        end
        `TBFR_REG_FD_DIV_CTRL: begin
            rd_data = freq_detect_divider_ctrl_reg;
        end
        `TBFR_REG_TX_STATUS: begin
            rd_data[`TBFR_BIT_TX_FAULT] = tx_fault_flag;
        end
        default: begin
            rd_data = 8'h00;
        end
    endcase
end

// ==========================================
// two-wire slave
always @(posedge sys_clk) begin
    if (!rst_n) begin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        shreg <= 8'h00;
        reg_ptr <= 8'h00;
        rw <= 1'b0;
        sda_oe <= 1'b0;
        sda_out <= 1'b0;
        bias_code_high <= `TBFR_RST_REG;
        monitor_select_bias_low <= `TBFR_RST_REG;
        bias_fault_threshold_reg <= `TBFR_RST_REG;
        power_fault_threshold_reg <= `TBFR_RST_REG;
        freq_detect_divider_ctrl_reg <= `TBFR_RST_REG;
    end else if (bus_start) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
    end else if (bus_stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
    end else begin
        case (state)
            ST_ADDR, ST_REG, ST_WDATA: begin
                if (scl_rise && bit_cnt != `TBFR_BITS_PER_BYTE) begin
                    shreg <= {shreg[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (scl_fall && bit_cnt == `TBFR_BITS_PER_BYTE) begin
                    bit_cnt <= 4'h0;
                    if (state == ST_ADDR) begin
                        if (shreg[7:1] == DEV_ADDR) begin
                            rw <= shreg[0];
                            sda_oe <= 1'b1;
                            state <= ST_ADDR_ACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (state == ST_REG) begin
                        reg_ptr <= shreg;
                        sda_oe <= 1'b1;
                        state <= ST_REG_ACK;
                    end else begin
                        sda_oe <= 1'b1;
                        state <= ST_WDATA_ACK;
                        case (reg_ptr)
                            `TBFR_REG_BIAS_HIGH: begin
                                bias_code_high <= shreg;
                            end
                            `TBFR_REG_MON_SEL_LOW: begin
                                monitor_select_bias_low <= shreg;
                            end
                            `TBFR_REG_BIAS_FAULT_TH: begin
                                bias_fault_threshold_reg <= shreg;
                            end
                            `TBFR_REG_POWER_FAULT_TH: begin
                                power_fault_threshold_reg <= shreg;
                            end
                            `TBFR_REG_FD_DIV_CTRL: begin
                                freq_detect_divider_ctrl_reg <= shreg;
                            end
                            default: begin
                                bit_cnt <= 4'h0;
                            end
                        endcase
                    end
                end
            end
            ST_ADDR_ACK: begin
                if (scl_fall) begin
                    if (rw) begin
                        shreg <= rd_data;
                        sda_oe <= !rd_data[7];
                        bit_cnt <= 4'h1;
                        state <= ST_RDATA;
                    end else begin
                        sda_oe <= 1'b0;
                        state <= ST_REG;
                    end
                end
            end
            ST_REG_ACK: begin
                if (scl_fall) begin
                    sda_oe <= 1'b0;
                    state <= ST_WDATA;
                end
            end
            ST_WDATA_ACK: begin
                if (scl_fall) begin
                    sda_oe <= 1'b0;
                    reg_ptr <= reg_ptr + 8'h01;
                    state <= ST_WDATA;
                end
            end
            ST_RDATA: begin
                if (scl_fall) begin
                    if (bit_cnt == `TBFR_BITS_PER_BYTE) begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                        reg_ptr <= reg_ptr + 8'h01;
                        state <= ST_RDATA_ACK;
                    end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe <= !shreg[6];
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
            end
            ST_RDATA_ACK: begin
                if (scl_rise && sda_s) begin
                    state <= ST_IDLE;
                end else if (scl_fall) begin
                    shreg <= rd_data;
                    sda_oe <= !rd_data[7];
                    bit_cnt <= 4'h1;
                    state <= ST_RDATA;
                end
            end
            default: begin
                sda_oe <= 1'b0;
                state <= ST_IDLE;
            end
        endcase
    end
end

// ==========================================
// outputs to the analog side
always @(posedge sys_clk) begin
    if (!rst_n) begin
        laser_bias_code <= 10'h000;
        bias_step_na <= 18'h00000;
        pd_monitor_digital_sel <= 1'b0;
        bias_monitor_digital_sel <= 1'b0;
        bias_fault_threshold <= 8'h00;
        power_fault_threshold <= 8'h00;
        freq_detect_divider_ctrl <= 8'h00;
        tx_fault_flag <= 1'b0;
    end else begin
        laser_bias_code <= {bias_code_high,
            monitor_select_bias_low[`TBFR_BIAS_LOW_MSB:0]};
        if (closed_loop_power_control) begin
            case (monitor_pd_range)
                2'h0: begin
                    bias_step_na <= `TBFR_STEP_RANGE0_NA;
                end
                2'h1: begin
                    bias_step_na <= `TBFR_STEP_RANGE1_NA;
                end
                default: begin
                    bias_step_na <= `TBFR_STEP_RANGE2_NA;
                end
            endcase
        end else begin
            bias_step_na <= `TBFR_STEP_OPEN_NA;
        end
        pd_monitor_digital_sel <= monitor_select_bias_low[`TBFR_BIT_PD_DIG_SEL];
        bias_monitor_digital_sel <= monitor_select_bias_low[`TBFR_BIT_BIAS_DIG_SEL];
        bias_fault_threshold <= bias_fault_threshold_reg;
        power_fault_threshold <= power_fault_threshold_reg;
        freq_detect_divider_ctrl <= freq_detect_divider_ctrl_reg;
        tx_fault_flag <= bias_fault || pd_fault;
    end
end

endmodule

/* hdl/tbfr_consts.vh */
`ifndef TBFR_CONSTS_VH
`define TBFR_CONSTS_VH

// ==========================================
// register numbers on the two-wire port
`define TBFR_REG_BIAS_HIGH      8'h0F
`define TBFR_REG_MON_SEL_LOW    8'h10
`define TBFR_REG_BIAS_FAULT_TH  8'h11
`define TBFR_REG_POWER_FAULT_TH 8'h12
`define TBFR_REG_FD_DIV_CTRL    8'h13
`define TBFR_REG_TX_STATUS      8'h2B

// ==========================================
// field positions
`define TBFR_BIT_PD_DIG_SEL     6
`define TBFR_BIT_BIAS_DIG_SEL   5
`define TBFR_BIT_TX_FAULT       5
`define TBFR_BIAS_LOW_MSB       1

// ==========================================
// reset values
`define TBFR_RST_REG            8'h00

// ==========================================
// bias step per code, in nA
`define TBFR_STEP_RANGE0_NA     18'h002EE
`define TBFR_STEP_RANGE1_NA     18'h005DC
`define TBFR_STEP_RANGE2_NA     18'h00BB8
`define TBFR_STEP_OPEN_NA       18'h26160

// ==========================================
// serial port
`define TBFR_DEV_ADDR_DEFAULT   7'h08
`define TBFR_BITS_PER_BYTE      4'h8

`endif

/* hdl/tbfr_fault_cmp.v */
`include "tbfr_consts.vh"

module tbfr_fault_cmp #(
    parameter WIDTH = 8
) (
    input wire sys_clk,
    input wire rst_n,
    input wire enable,
    input wire [WIDTH-1:0] level,
    input wire [WIDTH-1:0] threshold,
    output reg fault
);

// ==========================================
// compare only while this digital monitor is selected
always @(posedge sys_clk) begin
    if (!rst_n) begin
        fault <= 1'b0;
    end else begin
        fault <= enable && (level >= threshold);
    end
end

endmodule

/* sim/tbfr_regs_chk.sv */
// ====
// output checks for the register bank
module tbfr_regs_chk #(
    parameter LEVEL_W = 8
) (
    input wire sys_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    input wire closed_loop_power_control,
    input wire [1:0] monitor_pd_range,
    input wire [LEVEL_W-1:0] bias_monitor_level,
    input wire [LEVEL_W-1:0] pd_monitor_level,
    input wire [9:0] laser_bias_code,
    input wire [17:0] bias_step_na,
    input wire pd_monitor_digital_sel,
    input wire bias_monitor_digital_sel,
    input wire [7:0] bias_fault_threshold,
    input wire [7:0] power_fault_threshold,
    input wire [7:0] freq_detect_divider_ctrl,
    input wire tx_fault_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire cond = (bias_monitor_digital_sel && bias_monitor_level >= bias_fault_threshold) ||
        (pd_monitor_digital_sel && pd_monitor_level >= power_fault_threshold);
    wire [17:0] step_exp = !closed_loop_power_control ? 18'h26160 :
        monitor_pd_range[1] ? 18'h00BB8 : monitor_pd_range[0] ? 18'h005DC : 18'h002EE;
    wire [35:0] cfg = {laser_bias_code, pd_monitor_digital_sel, bias_monitor_digital_sel,
        bias_fault_threshold, power_fault_threshold, freq_detect_divider_ctrl};
    sequence fault_held; cond [*3]; endsequence
    sequence clear_held; !cond [*3]; endsequence
    sequence bus_idle; scl_in [*8]; endsequence
    // ====
    // assertions
    closed_step_a: assert property (rst_n |=> bias_step_na == $past(step_exp))
        else $error("bias step wrong");
    open_step_a: assert property (!closed_loop_power_control |=> bias_step_na == 18'h26160)
        else $error("open loop step wrong");
    fault_set_a: assert property (fault_held |-> tx_fault_flag)
        else $error("fault flag missing");
    fault_clear_a: assert property (clear_held |-> !tx_fault_flag)
        else $error("fault flag stuck");
    cfg_hold_a: assert property (bus_idle |-> $stable(cfg))
        else $error("config changed without access");
    ack_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved with clock high");
    reset_zero_a: assert property ($rose(rst_n) |-> cfg == 36'h0 && !tx_fault_flag && !sda_oe)
        else $error("outputs not zero after reset");
    sda_drive_a: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data line driven high");
endmodule

bind tbfr_regs tbfr_regs_chk #(.LEVEL_W(LEVEL_W)) u_chk (.sys_clk, .rst_n, .scl_in, .sda_out,
    .sda_oe, .closed_loop_power_control, .monitor_pd_range, .bias_monitor_level,
    .pd_monitor_level, .laser_bias_code, .bias_step_na, .pd_monitor_digital_sel,
    .bias_monitor_digital_sel, .bias_fault_threshold, .power_fault_threshold,
    .freq_detect_divider_ctrl, .tx_fault_flag);

/* sim/testbench.sv */
`include "tbfr_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst_n, scl_in, sda_m, closed_loop_power_control;
    logic [1:0] monitor_pd_range;
    logic [7:0] bias_monitor_level, pd_monitor_level;
    wire sda_out, sda_oe, pd_monitor_digital_sel, bias_monitor_digital_sel, tx_fault_flag;
    wire [9:0] laser_bias_code;
    wire [17:0] bias_step_na;
    wire [7:0] bias_fault_threshold, power_fault_threshold, freq_detect_divider_ctrl;
    wire sda_in = sda_oe ? sda_out : sda_m;
    int fails, num_checks;
    logic [7:0] pat [5] = '{8'hA5, 8'h9F, 8'h3C, 8'hC3, 8'h5A};
    logic [17:0] steps [5] = '{18'h002EE, 18'h005DC, 18'h00BB8, 18'h00BB8, 18'h26160};

    tbfr_regs DUT (.sys_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
        .closed_loop_power_control, .monitor_pd_range, .bias_monitor_level,
        .pd_monitor_level, .laser_bias_code, .bias_step_na, .pd_monitor_digital_sel,
        .bias_monitor_digital_sel, .bias_fault_threshold, .power_fault_threshold,
        .freq_detect_divider_ctrl, .tx_fault_flag);

    // ====
    // two-wire master
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ph;
        repeat (10) @(posedge sys_clk);
    endtask
    task automatic sta;
        sda_m <= 1'b1;
        ph;
        scl_in <= 1'b1;
        ph;
        sda_m <= 1'b0;
        ph;
        scl_in <= 1'b0;
    endtask
    task automatic sto;
        ph;
        sda_m <= 1'b0;
        ph;
        scl_in <= 1'b1;
        ph;
        sda_m <= 1'b1;
        ph;
    endtask
    task automatic xb(input logic b, output logic r);
        ph;
        sda_m <= b;
        ph;
        scl_in <= 1'b1;
        ph;
        r = sda_in;
        scl_in <= 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q,
                         output logic k);
        for (int i = 7; i >= 0; i--) xb(d[i], q[i]);
        xb(m, k);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic k0, k1, k2;
        sta;
        xbyte(8'h10, 1'b1, q, k0);
        xbyte(a, 1'b1, q, k1);
        xbyte(d, 1'b1, q, k2);
        sto;
        chk({k0, k1, k2}, 3'b000);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] x, q;
        logic k0, k1, k2, k3;
        sta;
        xbyte(8'h10, 1'b1, x, k0);
        xbyte(a, 1'b1, x, k1);
        sta;
        xbyte(8'h11, 1'b1, x, k2);
        xbyte(8'hFF, 1'b1, q, k3);
        sto;
        chk({k0, k1, k2, q}, {3'b000, e});
    endtask
    task automatic flt(input logic [7:0] b, input logic [7:0] p, input logic e);
        bias_monitor_level <= b;
        pd_monitor_level <= p;
        repeat (4) @(posedge sys_clk);
        chk(tx_fault_flag, e);
    endtask
    task automatic finish_test;
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ====
    // clock, watchdog, tests
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #2000000;
        fails++;
        finish_test;
    end
    initial begin
        logic [7:0] x;
        logic k;
        {rst_n, scl_in, sda_m, closed_loop_power_control, monitor_pd_range} = 6'h18;
        {bias_monitor_level, pd_monitor_level, fails, num_checks} = '0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 5; i++) rc(`TBFR_REG_BIAS_HIGH + 8'(i), 8'h00);
        rc(`TBFR_REG_TX_STATUS, 8'h00);
        for (int i = 0; i < 5; i++) wr(`TBFR_REG_BIAS_HIGH + 8'(i), pat[i]);
        for (int i = 0; i < 5; i++) rc(`TBFR_REG_BIAS_HIGH + 8'(i), pat[i]);
        chk(laser_bias_code, {8'hA5, 2'b11});
        chk({pd_monitor_digital_sel, bias_monitor_digital_sel}, 2'b00);
        chk({bias_fault_threshold, power_fault_threshold, freq_detect_divider_ctrl}, 24'h3CC35A);
        wr(8'h10, 8'h60);
        chk({pd_monitor_digital_sel, bias_monitor_digital_sel, laser_bias_code}, 12'hE94);
        wr(8'h14, 8'h77);
        rc(8'h14, 8'h00);
        wr(`TBFR_REG_TX_STATUS, 8'hFF);
        rc(`TBFR_REG_TX_STATUS, 8'h00);
        sta;
        xbyte(8'h12, 1'b1, x, k);
        sto;
        chk(k, 1'b1);
        for (int i = 0; i < 5; i++) begin
            closed_loop_power_control <= (i < 4);
            monitor_pd_range <= 2'(i);
            repeat (3) @(posedge sys_clk);
            chk(bias_step_na, steps[i]);
        end
        wr(8'h11, 8'h40);
        wr(8'h12, 8'h80);
        wr(8'h10, 8'h20);
        flt(8'h3F, 8'hFF, 1'b0);
        flt(8'h40, 8'h00, 1'b1);
        rc(`TBFR_REG_TX_STATUS, 8'h20);
        wr(8'h10, 8'h40);
        flt(8'hFF, 8'h7F, 1'b0);
        flt(8'h00, 8'h80, 1'b1);
        wr(8'h11, 8'h00);
        wr(8'h10, 8'h20);
        flt(8'h00, 8'h00, 1'b1);
        rc(`TBFR_REG_TX_STATUS, 8'h20);
        finish_test;
    end
endmodule
